// file: logic/asramc_consts.vh
// Constants for the asynchronous static memory word-port controller
`ifndef ASRAMC_CONSTS_VH
`define ASRAMC_CONSTS_VH

// ****************************************************************
// Geometry
// ****************************************************************
`define ASRAMC_ADDR_W 19
`define ASRAMC_DATA_W 16
`define ASRAMC_WORDS 524288

// ****************************************************************
// Clock period in ps, pin timing in ns
// ****************************************************************
`define ASRAMC_CLK_PS 25000
`define ASRAMC_T_RC_NS 55
`define ASRAMC_T_WC_NS 55
`define ASRAMC_T_WP_NS 45
`define ASRAMC_T_AW_NS 50
`define ASRAMC_T_CW_NS 50
`define ASRAMC_T_BW_NS 45
`define ASRAMC_T_DW_NS 25
`define ASRAMC_T_WHZ_NS 20
`define ASRAMC_T_OHZ_NS 20
`define ASRAMC_T_CHZ_NS 20

// Least times round up to whole cycles
`define ASRAMC_CYC_UP(ns) (((ns) * 1000 + `ASRAMC_CLK_PS - 1) / `ASRAMC_CLK_PS)
`define ASRAMC_RD_CYC `ASRAMC_CYC_UP(`ASRAMC_T_RC_NS)
`define ASRAMC_WP_CYC `ASRAMC_CYC_UP(`ASRAMC_T_WHZ_NS + `ASRAMC_T_DW_NS)
`define ASRAMC_REL_CYC `ASRAMC_CYC_UP(`ASRAMC_T_OHZ_NS)

`endif

// file: logic/asramc_ctrl.v
// Host controller driving an asynchronous 512K x 16 static memory by its pins
`timescale 1ns/1ps
`include "asramc_consts.vh"

// What this block does
// - write_strobe_n stays high throughout every read.
// - word_index changes only while write_strobe_n and chip_select_n are high.
// - word_index is set one cycle before selects assert.
// - Index valid before and through the strobe; write cycle at least 55 ns.
// - Chip selects active across the whole strobe, well over 50 ns.
// - Lanes and strobe held at least 45 ns.
// - Strobe width covers turn-off plus data overlap, 45 ns.
// - Data drive only while output gate is high and release time has passed.
// - Retention request deselects through chip_select_n before ack.
module asramc_ctrl #(
	parameter AW = `ASRAMC_ADDR_W,
	parameter DW = `ASRAMC_DATA_W
) (
	input wire clk,
	input wire rst,
	input wire req_valid,
	input wire req_write,
	input wire [AW-1:0] req_index,
	input wire [DW-1:0] req_wdata,
	input wire [1:0] req_lanes,
	input wire retain_req,
	output reg req_ready,
	output reg rsp_valid,
	output reg [DW-1:0] rsp_rdata,
	output reg retain_ack,
	output reg [AW-1:0] word_index,
	output reg chip_select_n,
	output reg chip_select_hi,
	output reg write_strobe_n,
	output reg output_gate_n,
	output reg low_lane_n,
	output reg high_lane_n,
	output reg [DW-1:0] data_lines_out,
	output reg data_lines_oe,
	input wire [DW-1:0] data_lines_in
);

	// ****************************************************************
	// States
	// ****************************************************************
	localparam [6:0] S_IDLE = 7'h01;
	localparam [6:0] S_SETUP = 7'h02;
	localparam [6:0] S_READ = 7'h04;
	localparam [6:0] S_WRITE = 7'h08;
	localparam [6:0] S_RECOV = 7'h10;
	localparam [6:0] S_RETAIN = 7'h20;
	localparam [6:0] S_REL = 7'h40;

	// Counts stay well under sixteen cycles, so four bits of the span timer suffice
	localparam integer RD_CYC_I = `ASRAMC_RD_CYC;
	localparam integer WP_CYC_I = `ASRAMC_WP_CYC;
	localparam integer REL_CYC_I = `ASRAMC_REL_CYC;
	localparam [3:0] RD_CYC = RD_CYC_I[3:0];
	localparam [3:0] WP_CYC = WP_CYC_I[3:0];
	localparam [3:0] REL_CYC = REL_CYC_I[3:0];

	reg [6:0] state;
	reg [1:0] req_lanes_q;
	reg is_write;
	reg [DW-1:0] rd_sync1;
	reg [DW-1:0] rd_sync2;
	reg span_load;
	reg [3:0] span_count;
	wire span_done;

	asramc_span #(
		.W(4)
	) u_span (
		.clk(clk),
		.rst(rst),
		.load(span_load),
		.count(span_count),
		.done(span_done)
	);

	// ****************************************************************
	// Read data capture
	// ****************************************************************
	// Pin inputs pass two flops; the extra delay is covered by sampling late
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_sync1 <= {DW{1'b0}};
			rd_sync2 <= {DW{1'b0}};
		end else begin
			rd_sync1 <= data_lines_in;
			rd_sync2 <= rd_sync1;
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= S_IDLE;
			is_write <= 1'b0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= {DW{1'b0}};
			retain_ack <= 1'b0;
			word_index <= {AW{1'b0}};
			chip_select_n <= 1'b1;
			chip_select_hi <= 1'b0;
			write_strobe_n <= 1'b1;
			output_gate_n <= 1'b1;
			low_lane_n <= 1'b1;
			high_lane_n <= 1'b1;
			data_lines_out <= {DW{1'b0}};
			data_lines_oe <= 1'b0;
			span_load <= 1'b0;
			span_count <= 4'h0;
		end else begin
			span_load <= 1'b0;
			rsp_valid <= 1'b0;
			req_ready <= 1'b0;
			case (state)
			S_IDLE: begin
				if (retain_req) begin
					chip_select_n <= 1'b1;
					chip_select_hi <= 1'b0;
					retain_ack <= 1'b1;
					state <= S_RETAIN;
				end else if (req_valid) begin
					// chip_select_n is high and chip_select_hi low here, so the index may move
					word_index <= req_index;
					is_write <= req_write;
					data_lines_out <= req_wdata;
					req_ready <= 1'b1;
					state <= S_SETUP;
				end else begin
					req_ready <= 1'b0;
				end
			end
			S_SETUP: begin
				chip_select_n <= 1'b0;
				chip_select_hi <= 1'b1;
				low_lane_n <= ~req_lanes_q[0];
				high_lane_n <= ~req_lanes_q[1];
				output_gate_n <= is_write;
				span_load <= 1'b1;
				span_count <= is_write ? WP_CYC : RD_CYC + 4'h2;
				if (is_write) begin
					data_lines_oe <= 1'b1;
					state <= S_WRITE;
				end else begin
					state <= S_READ;
				end
			end
			S_WRITE: begin
				write_strobe_n <= 1'b0;
				if (span_done) begin
					write_strobe_n <= 1'b1;
					state <= S_RECOV;
				end
			end
			S_READ: begin
				if (span_done) begin
					rsp_rdata <= rd_sync2;
					rsp_valid <= 1'b1;
					state <= S_RECOV;
				end
			end
			S_RECOV: begin
				// Strobe rises before selects drop and data stops driving
				chip_select_n <= 1'b1;
				chip_select_hi <= 1'b0;
				low_lane_n <= 1'b1;
				high_lane_n <= 1'b1;
				output_gate_n <= 1'b1;
				data_lines_oe <= 1'b0;
				span_load <= 1'b1;
				span_count <= REL_CYC;
				state <= S_REL;
			end
			S_REL: begin
				if (span_done) begin
					state <= S_IDLE;
				end
			end
			S_RETAIN: begin
				if (!retain_req) begin
					retain_ack <= 1'b0;
					span_load <= 1'b1;
					span_count <= RD_CYC;
					state <= S_REL;
				end
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end

	// ****************************************************************
	// Lane capture
	// ****************************************************************
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			req_lanes_q <= 2'h0;
		end else if (state == S_IDLE && req_valid && !retain_req) begin
			req_lanes_q <= req_lanes;
		end
	end

endmodule // asramc_ctrl

// file: logic/asramc_span.v
// Down counter that times one phase of a memory cycle
`timescale 1ns/1ps

module asramc_span #(
	parameter W = 4
) (
	input wire clk,
	input wire rst,
	input wire load,
	input wire [W-1:0] count,
	output reg done
);

	reg [W-1:0] left;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			left <= {W{1'b0}};
			done <= 1'b0;
		end else if (load) begin
			left <= count;
			done <= 1'b0;
		end else if (left != {W{1'b0}}) begin
			left <= left - {{(W-1){1'b0}}, 1'b1};
			done <= (left == {{(W-1){1'b0}}, 1'b1});
		end else begin
			done <= 1'b0;
		end
	end

endmodule // asramc_span

// file: sim/asramc_mem.sv
// Behavioural model of the static memory behind the controller
`timescale 1ns/1ps
module asramc_mem (
	input wire [18:0] word_index,
	input wire chip_select_n,
	input wire chip_select_hi,
	input wire write_strobe_n,
	input wire output_gate_n,
	input wire low_lane_n,
	input wire high_lane_n,
	input wire [15:0] din,
	output logic [15:0] dq,
	output logic [1:0] dq_oe
);
	logic [15:0] mem [0:524287];
	int acc = 20;
	wire sel = !chip_select_n && chip_select_hi;
	wire [1:0] ln = {!high_lane_n, !low_lane_n};
	// Strobe low never drives, so late selects in a write stay floating
	wire [1:0] rd = (sel && write_strobe_n && !output_gate_n) ? ln : 2'b00;
	initial dq_oe = 2'b00;
	always @(posedge write_strobe_n) begin
		if (sel && ln[0]) mem[word_index][7:0] = din[7:0];
		if (sel && ln[1]) mem[word_index][15:8] = din[15:8];
	end
	// Old data stays until the access time runs out
	always @(rd or word_index) begin
		dq <= #(acc) mem[word_index];
		dq_oe <= #(rd == 2'b00 ? 15 : acc) rd;
	end
endmodule // asramc_mem

// file: sim/asramc_props.sv
// Pin-timing assertions for the memory controller
`timescale 1ns/1ps
module asramc_props (
	input wire clk,
	input wire rst,
	input wire retain_ack,
	input wire [18:0] word_index,
	input wire chip_select_n,
	input wire chip_select_hi,
	input wire write_strobe_n,
	input wire output_gate_n,
	input wire data_lines_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_rd_no_strobe: assert property (!output_gate_n |-> write_strobe_n)
		else $error("strobe low in read");
	a_idx_held_sel: assert property (!chip_select_n |=> $stable(word_index))
		else $error("index moved while selected");
	a_idx_setup: assert property ($fell(chip_select_n) |-> $stable(word_index))
		else $error("index late");
	a_sel_first: assert property ($fell(write_strobe_n) |->
		!$past(chip_select_n) && $past(chip_select_hi)) else $error("strobe before select");
	a_strobe_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n[*2])
		else $error("strobe short");
	a_wr_sel_span: assert property ($rose(write_strobe_n) |->
		!$past(chip_select_n, 3) && !chip_select_n) else $error("select short");
	a_wr_idx_hold: assert property ($rose(write_strobe_n) |->
		word_index == $past(word_index, 3)) else $error("index hold short");
	a_drive_gate_off: assert property ($rose(data_lines_oe) |->
		output_gate_n && $past(output_gate_n, 2)) else $error("drive under gate");
	a_ret_desel: assert property (retain_ack |-> chip_select_n && !data_lines_oe)
		else $error("retain while selected");
	a_rd_span: assert property ($fell(output_gate_n) |->
		(!chip_select_n && !output_gate_n)[*3]) else $error("read short");
	c_read: cover property ($fell(output_gate_n));
	c_write: cover property ($rose(write_strobe_n));
	c_retain: cover property ($rose(retain_ack));
endmodule // asramc_props

// file: sim/test_asramc_ctrl.sv
// Self-checking bench for the memory controller
`timescale 1ns/1ps
module test_asramc_ctrl;
	logic clk = 0, rst = 1, req_valid = 0, req_write = 0, retain_req = 0;
	logic [18:0] req_index = 0, word_index;
	logic [15:0] req_wdata = 0, rsp_rdata, data_lines_out, data_lines_in, dq;
	logic [1:0] req_lanes = 0, dq_oe;
	logic req_ready, rsp_valid, retain_ack, chip_select_n, chip_select_hi;
	logic write_strobe_n, output_gate_n, low_lane_n, high_lane_n, data_lines_oe;
	int miscompares = 0, check_count = 0;
	asramc_ctrl i_asramc_ctrl (.*);
	asramc_mem i_asramc_mem (.din(data_lines_in), .*);
	// Released lanes show the inverse of the last value
	always @* for (int i = 0; i < 16; i++)
		data_lines_in[i] = data_lines_oe ? data_lines_out[i] : dq_oe[i/8] ? dq[i] : ~dq[i];
	initial forever #12.5 clk = ~clk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_hi(input int which);
		int n = 0;
		do begin
			@(posedge clk);
			#1;
		end while ((which == 0 ? req_ready : which == 1 ? rsp_valid : retain_ack) !== 1'b1
			&& ++n < 40);
		check(16'(n < 40), 16'h0001);
	endtask
	task automatic req(input logic w, input logic [18:0] idx, input logic [15:0] wd,
		input logic [1:0] ln, output logic [15:0] r);
		@(negedge clk);
		{req_valid, req_write, req_index, req_wdata, req_lanes} = {1'b1, w, idx, wd, ln};
		wait_hi(0);
		@(negedge clk);
		req_valid = 0;
		if (!w) begin
			wait_hi(1);
			r = rsp_rdata;
		end
	endtask
	task automatic t_basic();
		logic [15:0] r;
		req(1, 19'h00000, 16'hA5C3, 2'h3, r);
		req(1, 19'h7FFFF, 16'h5A3C, 2'h3, r);
		req(0, 19'h00000, 16'h0000, 2'h3, r);
		check(r, 16'hA5C3);
		req(0, 19'h7FFFF, 16'h0000, 2'h3, r);
		check(r, 16'h5A3C);
	endtask
	task automatic t_lanes();
		logic [15:0] r;
		req(1, 19'h7FFFF, 16'h1234, 2'h1, r);
		req(0, 19'h7FFFF, 16'h0000, 2'h3, r);
		check(r, 16'h5A34);
		req(0, 19'h00000, 16'h0000, 2'h2, r);
		check({r[15:8], 8'h00}, 16'hA500);
	endtask
	task automatic t_slow();
		logic [15:0] r;
		i_asramc_mem.acc = 55;
		req(1, 19'h2AAAA, 16'hF00F, 2'h3, r);
		req(0, 19'h2AAAA, 16'h0000, 2'h3, r);
		check(r, 16'hF00F);
		i_asramc_mem.acc = 20;
	endtask
	task automatic t_retain();
		@(negedge clk);
		{retain_req, req_valid} = 2'b11;
		wait_hi(2);
		check(16'(chip_select_n), 16'h0001);
		repeat (5) begin
			@(posedge clk);
			#1;
			check(16'(req_ready), 16'h0000);
		end
		@(negedge clk);
		{retain_req, req_valid} = 2'b00;
	endtask
	always @(negedge clk) check(16'(data_lines_oe & |dq_oe), 16'h0000);
	task automatic give_verdict();
		if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst = 0;
		t_basic();
		t_lanes();
		t_slow();
		t_retain();
		give_verdict();
	end
	initial begin
		#100000;
		miscompares++;
		give_verdict();
	end
endmodule // test_asramc_ctrl
bind asramc_ctrl asramc_props i_asramc_props (.*);
